// ---- design/adc_regmap_pkg.sv ----
package adc_regmap_pkg;

   // Register address space and decode boundaries.
   localparam int          ADDR_W       = 13;
   localparam logic [12:0] ADDR_SETUP   = 13'h0000;
   localparam logic [12:0] ADDR_PART_ID = 13'h0001;
   localparam logic [12:0] ADDR_GRADE   = 13'h0002;
   localparam logic [12:0] ADDR_FUNC_LO = 13'h0008;
   localparam logic [12:0] ADDR_FUNC_HI = 13'h0020;
   localparam logic [12:0] ADDR_FORMAT  = 13'h0014;
   localparam logic [12:0] ADDR_CLOCK   = 13'h0009;
   localparam logic [12:0] ADDR_COMMIT  = 13'h00FF;
   localparam int          FUNC_COUNT   = 25;

   // Reset values.
   localparam logic [7:0] SETUP_RESET  = 8'h18;
   localparam logic [7:0] FORMAT_RESET = 8'h01;
   localparam logic [7:0] CLOCK_RESET  = 8'h01;
   localparam logic [FUNC_COUNT*8-1:0] FUNC_RESET =
      ({{(FUNC_COUNT*8-8){1'b0}}, FORMAT_RESET} << (8 * 12)) |
      ({{(FUNC_COUNT*8-8){1'b0}}, CLOCK_RESET} << (8 * 1));

   // Field positions.
   localparam int         SETUP_LSB_HI  = 6;
   localparam int         SETUP_SRST_HI = 5;
   localparam int         SETUP_SRST_LO = 2;
   localparam int         SETUP_LSB_LO  = 1;
   localparam int         GRADE_LSB     = 4;
   localparam int         COMMIT_BIT    = 0;
   localparam logic [7:0] COMMIT_VALUE  = 8'h01;

   // Serial instruction layout.
   localparam logic [3:0] INSTR_LAST   = 4'hF;
   localparam logic [3:0] BYTE_LAST    = 4'h7;
   localparam int         INSTR_RW_BIT = 15;
   localparam logic [1:0] LEN_STREAM   = 2'h3;

   typedef enum logic [1:0] {
      ST_IDLE, ST_INSTR, ST_DATA, ST_END
   } port_state_type;

endpackage : adc_regmap_pkg

// ---- design/shadow_bank.sv ----
`timescale 1ns/1ps
`default_nettype none

module shadow_bank #(
   parameter int N = 25
) (
   // Clock and reset.
   input  wire logic           clock_i,
   input  wire logic           rst_n_i,
   input  wire logic           ce_i,
   // Write side.
   input  wire logic           wr_i,
   input  wire logic [4:0]     idx_i,
   input  wire logic [7:0]     wdata_i,
   input  wire logic           commit_i,
   input  wire logic           clear_i,
   // Register contents.
   output logic      [N*8-1:0] shadow_o,
   output logic      [N*8-1:0] active_o
);

   logic [N*8-1:0] shadow_r;
   logic [N*8-1:0] shadow_nxt;
   logic [N*8-1:0] active_r;
   logic [N*8-1:0] active_nxt;

   // Writes land only in the shadow copy; the active copy moves as a whole
   // on commit so the converter never sees a half-updated setting.
   always_comb begin
      shadow_nxt = shadow_r;
      active_nxt = active_r;
      if (clear_i) begin
         shadow_nxt = adc_regmap_pkg::FUNC_RESET;
         active_nxt = adc_regmap_pkg::FUNC_RESET;
      end else begin
         if (wr_i) begin
            shadow_nxt[idx_i*8 +: 8] = wdata_i; // see R6
         end
         if (commit_i) begin
            active_nxt = shadow_r; // see R7
         end
      end
   end

   // Register stage; the clock enable freezes both copies.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shadow_r <= adc_regmap_pkg::FUNC_RESET; // see R5
         active_r <= adc_regmap_pkg::FUNC_RESET; // see R11
      end else if (ce_i) begin
         shadow_r <= shadow_nxt;
         active_r <= active_nxt;
      end
   end

   assign shadow_o = shadow_r;
   assign active_o = active_r;

   commit_copy_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      ce_i && commit_i && !clear_i |=> active_r == $past(shadow_r)) // see R7
      else $error("Commit did not copy shadow to active.");

   shadow_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !(ce_i && (commit_i || clear_i)) |=> $stable(active_r)) // see R6
      else $error("Active copy moved without a commit.");

   format_default_a: assert property (@(posedge clock_i)
      $rose(rst_n_i) |-> active_r[12*8 +: 8] == 8'h01) // see R11
      else $error("Output format did not reset to two's complement.");

endmodule : shadow_bank

`default_nettype wire

// ---- design/adc_config_register_map.sv ----
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: Decode config, commit and function register groups.
// R2: Every register is one byte, bit 7 MSB.
// R3: Master writes zeros into unused bits.
// R4: Master never writes fully open addresses.
// R5: Any reset reloads documented default values.
// R6: Function registers are shadowed until commit.
// R7: Writing 0x01 to 0xFF commits all shadows.
// R8: Commit bit clears itself after the update.
// R9: Port setup nibbles mirror bit order, soft reset.
// R10: Grade register is read-only, code in 5:4.
// R11: Output format resets to 0x01, two's complement.
// R12: All access goes through three-wire serial port.
// R13: Port shifts MSB first until software changes.
// R14: Configuration writes outside shadow range act immediately.
// R15: Unsupported writes ignored, unsupported reads return zero.
module adc_config_register_map #(
   parameter logic [7:0] PART_ID    = 8'h5A, // Arbitrary identity value.
   parameter logic [1:0] RATE_CLASS = 2'h0
) (
   // Clock, reset and enable.
   input  wire logic         clock_i,
   input  wire logic         rst_n_i,
   input  wire logic         ce_i,
   // Three-wire serial port.
   input  wire logic         csb_n_i,
   input  wire logic         sclk_i,
   input  wire logic         sdio_i,
   output logic              sdio_o,
   output logic              sdio_oe_o,
   // Committed function registers and port state.
   output logic      [199:0] active_regs_o,
   output logic              lsb_first_o
);

   localparam int NB = adc_regmap_pkg::FUNC_COUNT;

   logic rst_q1, rst_n_r;

   // Reset release through two flops so every flop behind them leaves reset together.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_q1  <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_q1  <= 1'b1;
         rst_n_r <= rst_q1;
      end
   end

   logic [2:0] pin_q1, pin_q2;
   logic       sclk_d;

   // Pins are asynchronous to the register clock; the edge detector only
   // looks at the second stage.
   always_ff @(posedge clock_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pin_q1 <= 3'h1;
         pin_q2 <= 3'h1;
         sclk_d <= 1'b0;
      end else if (ce_i) begin
         pin_q1 <= {sdio_i, sclk_i, csb_n_i};
         pin_q2 <= pin_q1;
         sclk_d <= pin_q2[1];
      end
   end

   logic csb_s, sdi_s;
   logic sclk_rise, sclk_fall;

   // Sampled pins and serial clock edges inside a frame.
   assign csb_s     = pin_q2[0];
   assign sdi_s     = pin_q2[2];
   assign sclk_rise = !csb_s && pin_q2[1] && !sclk_d;
   assign sclk_fall = !csb_s && !pin_q2[1] && sclk_d;

   adc_regmap_pkg::port_state_type state_r, state_nxt;
   logic [3:0]      cnt_r, cnt_nxt;
   logic [15:0]     sr_r, sr_nxt;
   logic [12:0]     addr_r, addr_nxt;
   logic            rd_r, rd_nxt;
   logic [1:0]      len_r, len_nxt;
   logic [1:0]      bytes_r, bytes_nxt;
   logic [7:0]      rbyte_r, rbyte_nxt;
   logic            sdo_r, sdo_nxt;
   logic            oe_r, oe_nxt;
   logic            wr_stb_r, wr_stb_nxt;
   logic [12:0]     wr_addr_r, wr_addr_nxt;
   logic [7:0]      wr_data_r, wr_data_nxt;
   logic            lsb_first_r, lsb_first_nxt;
   logic            commit_r, commit_nxt;
   logic            srst_r, srst_nxt;
   logic [NB*8-1:0] shadow;
   logic [7:0]      byte_in;

   // Read mux over the whole space; anything unsupported reads zero.
   function automatic logic [7:0] read_reg(input logic [12:0] a,
                                           input logic        lsb,
                                           input logic        cmt,
                                           input logic [NB*8-1:0] sh);
      logic [12:0] idx;
      idx = 13'h0000;
      read_reg = 8'h00; // see R15
      if (a == adc_regmap_pkg::ADDR_SETUP) begin
         read_reg = {1'b0, lsb, 1'b0, 1'b1, 1'b1, 1'b0, lsb, 1'b0}; // see R9
      end else if (a == adc_regmap_pkg::ADDR_PART_ID) begin
         read_reg = PART_ID;
      end else if (a == adc_regmap_pkg::ADDR_GRADE) begin
         read_reg = {2'h0, RATE_CLASS, 4'h0}; // see R10
      end else if (a == adc_regmap_pkg::ADDR_COMMIT) begin
         read_reg = {7'h00, cmt};
      end else if (a >= adc_regmap_pkg::ADDR_FUNC_LO &&
                   a <= adc_regmap_pkg::ADDR_FUNC_HI) begin // see R1
         idx = a - adc_regmap_pkg::ADDR_FUNC_LO;
         read_reg = sh[idx[4:0]*8 +: 8];
      end
   endfunction : read_reg

   // A completed data byte sits at the top of the shifter in LSB-first mode.
   assign byte_in = lsb_first_r ? sr_nxt[15:8] : sr_nxt[7:0]; // see R2

   // Serial frame engine: 16-bit instruction, then bytes until the length
   // runs out or, when streaming, until chip select rises.
   always_comb begin
      state_nxt   = state_r;
      cnt_nxt     = cnt_r;
      sr_nxt      = sr_r;
      addr_nxt    = addr_r;
      rd_nxt      = rd_r;
      len_nxt     = len_r;
      bytes_nxt   = bytes_r;
      rbyte_nxt   = rbyte_r;
      sdo_nxt     = sdo_r;
      oe_nxt      = oe_r;
      wr_stb_nxt  = 1'b0;
      wr_addr_nxt = wr_addr_r;
      wr_data_nxt = wr_data_r;
      if (sclk_rise) begin
         // Bit order follows the setup register, MSB first after reset.
         sr_nxt = lsb_first_r ? {sdi_s, sr_r[15:1]}
                              : {sr_r[14:0], sdi_s}; // see R13
      end
      if (csb_s) begin
         state_nxt = adc_regmap_pkg::ST_IDLE;
         cnt_nxt   = 4'h0;
         oe_nxt    = 1'b0;
      end else begin
         case (state_r)
            adc_regmap_pkg::ST_IDLE: begin
               state_nxt = adc_regmap_pkg::ST_INSTR;
               cnt_nxt   = 4'h0;
            end
            adc_regmap_pkg::ST_INSTR: begin
               if (sclk_rise) begin
                  cnt_nxt = cnt_r + 4'h1;
                  if (cnt_r == adc_regmap_pkg::INSTR_LAST) begin
                     rd_nxt    = sr_nxt[adc_regmap_pkg::INSTR_RW_BIT];
                     len_nxt   = sr_nxt[14:13];
                     addr_nxt  = sr_nxt[12:0];
                     bytes_nxt = 2'h0;
                     cnt_nxt   = 4'h0;
                     rbyte_nxt = read_reg(sr_nxt[12:0], lsb_first_r,
                                          commit_r, shadow);
                     state_nxt = adc_regmap_pkg::ST_DATA;
                  end
               end
            end
            adc_regmap_pkg::ST_DATA: begin
               if (sclk_fall && rd_r) begin
                  // Read data changes on the falling edge for the master.
                  sdo_nxt = lsb_first_r ? rbyte_r[cnt_r[2:0]]
                                        : rbyte_r[3'h7 - cnt_r[2:0]];
                  oe_nxt  = 1'b1;
               end
               if (sclk_rise) begin
                  cnt_nxt = cnt_r + 4'h1;
                  if (cnt_r == adc_regmap_pkg::BYTE_LAST) begin
                     cnt_nxt = 4'h0;
                     if (!rd_r) begin
                        wr_stb_nxt  = 1'b1; // see R12
                        wr_addr_nxt = addr_r;
                        wr_data_nxt = byte_in;
                     end
                     // Streams walk up in LSB-first mode, down otherwise.
                     addr_nxt  = lsb_first_r ? addr_r + 13'h0001
                                             : addr_r - 13'h0001;
                     rbyte_nxt = read_reg(addr_nxt, lsb_first_r,
                                          commit_r, shadow);
                     bytes_nxt = bytes_r + 2'h1;
                     if (len_r != adc_regmap_pkg::LEN_STREAM &&
                         bytes_r == len_r) begin
                        state_nxt = adc_regmap_pkg::ST_END;
                     end
                  end
               end
            end
            default: begin
               // Extra clocks after the last byte are ignored.
               oe_nxt = sclk_fall ? 1'b0 : oe_r;
            end
         endcase
      end
   end

   // Frame engine registers.
   always_ff @(posedge clock_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r   <= adc_regmap_pkg::ST_IDLE;
         cnt_r     <= 4'h0;
         sr_r      <= 16'h0000;
         addr_r    <= 13'h0000;
         rd_r      <= 1'b0;
         len_r     <= 2'h0;
         bytes_r   <= 2'h0;
         rbyte_r   <= 8'h00;
         sdo_r     <= 1'b0;
         oe_r      <= 1'b0;
         wr_stb_r  <= 1'b0;
         wr_addr_r <= 13'h0000;
         wr_data_r <= 8'h00;
      end else if (ce_i) begin
         state_r   <= state_nxt;
         cnt_r     <= cnt_nxt;
         sr_r      <= sr_nxt;
         addr_r    <= addr_nxt;
         rd_r      <= rd_nxt;
         len_r     <= len_nxt;
         bytes_r   <= bytes_nxt;
         rbyte_r   <= rbyte_nxt;
         sdo_r     <= sdo_nxt;
         oe_r      <= oe_nxt;
         wr_stb_r  <= wr_stb_nxt;
         wr_addr_r <= wr_addr_nxt;
         wr_data_r <= wr_data_nxt;
      end
   end

   logic in_func;
   logic [12:0] func_off;

   // Function-range decode for the shadow bank.
   assign in_func  = wr_addr_r >= adc_regmap_pkg::ADDR_FUNC_LO &&
                     wr_addr_r <= adc_regmap_pkg::ADDR_FUNC_HI; // see R1
   assign func_off = wr_addr_r - adc_regmap_pkg::ADDR_FUNC_LO;

   // Configuration registers act at once; read-only and unsupported
   // addresses drop the write. A soft reset request wins over everything.
   always_comb begin
      lsb_first_nxt = lsb_first_r;
      commit_nxt    = 1'b0; // see R8
      srst_nxt      = 1'b0;
      if (srst_r) begin
         lsb_first_nxt =
            adc_regmap_pkg::SETUP_RESET[adc_regmap_pkg::SETUP_LSB_HI];
      end else if (wr_stb_r) begin
         if (wr_addr_r == adc_regmap_pkg::ADDR_SETUP) begin
            // Either nibble's copy counts, whatever order it was shifted in.
            lsb_first_nxt = wr_data_r[adc_regmap_pkg::SETUP_LSB_HI] |
                            wr_data_r[adc_regmap_pkg::SETUP_LSB_LO]; // see R14
            srst_nxt      = wr_data_r[adc_regmap_pkg::SETUP_SRST_HI] |
                            wr_data_r[adc_regmap_pkg::SETUP_SRST_LO]; // see R9
         end else if (wr_addr_r == adc_regmap_pkg::ADDR_COMMIT) begin
            commit_nxt = wr_data_r[adc_regmap_pkg::COMMIT_BIT]; // see R7
         end
      end
   end

   // Configuration registers; soft reset bits are never stored.
   always_ff @(posedge clock_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         lsb_first_r <=
            adc_regmap_pkg::SETUP_RESET[adc_regmap_pkg::SETUP_LSB_HI];
         commit_r    <= 1'b0;
         srst_r      <= 1'b0;
      end else if (ce_i) begin
         lsb_first_r <= lsb_first_nxt; // see R5
         commit_r    <= commit_nxt;
         srst_r      <= srst_nxt;
      end
   end

   // Shadowed function registers with their committed copies.
   shadow_bank #(
      .N (NB)
   ) u_bank (
      .clock_i  (clock_i),
      .rst_n_i  (rst_n_r),
      .ce_i     (ce_i),
      .wr_i     (wr_stb_r && in_func && !srst_r),
      .idx_i    (func_off[4:0]),
      .wdata_i  (wr_data_r),
      .commit_i (commit_r),
      .clear_i  (srst_r),
      .shadow_o (shadow),
      .active_o (active_regs_o)
   );

   assign sdio_o      = sdo_r;
   assign sdio_oe_o   = oe_r;
   assign lsb_first_o = lsb_first_r;

   commit_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_r)
      ce_i && commit_r |=> !commit_r) // see R8
      else $error("Commit bit did not clear itself.");

   setup_default_a: assert property (@(posedge clock_i)
      $rose(rst_n_r) |-> !lsb_first_r && !commit_r) // see R5
      else $error("Setup register not at default after reset.");

   cfg_immediate_a: assert property (@(posedge clock_i) disable iff (!rst_n_r)
      ce_i && wr_stb_r && !srst_r && wr_addr_r == 13'h0000
      |=> lsb_first_r ==
          ($past(wr_data_r[6]) | $past(wr_data_r[1]))) // see R14
      else $error("Setup write did not act at once.");

   unmapped_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_r)
      ce_i && wr_stb_r && !srst_r && !in_func && wr_addr_r != 13'h0000
      && wr_addr_r != 13'h00FF
      |=> $stable(lsb_first_r) ##1 $stable(active_regs_o)) // see R15
      else $error("Unsupported write changed stored state.");

   grade_read_a: assert property (@(posedge clock_i) disable iff (!rst_n_r)
      ce_i && state_r == adc_regmap_pkg::ST_INSTR && sclk_rise
      && cnt_r == 4'hF && sr_nxt[12:0] == 13'h0002
      |=> rbyte_r == {2'h0, RATE_CLASS, 4'h0}) // see R10
      else $error("Grade register read returned wrong value.");

   oe_frame_a: assert property (@(posedge clock_i) disable iff (!rst_n_r)
      ce_i && csb_s |=> !sdio_oe_o) // see R12
      else $error("Data pin driven outside a frame.");

endmodule : adc_config_register_map

`default_nettype wire

// ---- verif/serial_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module serial_master_model #(
   parameter int PH = 6
) (
   // Clock and resolved data line.
   input  wire logic clock_i,
   input  wire logic sdio_i,
   // Serial port pins driven by the master.
   output logic      csb_n_o,
   output logic      sclk_o,
   output logic      sdio_o,
   output logic      sdio_oe_o
);

   // Idle frame: chip select high, serial clock resting low.
   initial begin
      csb_n_o   = 1'b1;
      sclk_o    = 1'b0;
      sdio_o    = 1'b0;
      sdio_oe_o = 1'b0;
   end

   // Waits n register clocks and lands just after the edge.
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : tick

   // One framed transfer of len+1 bytes, two at most, so streaming is never
   // asked for; byte k of the frame sits in bits 8k+7:8k. Each phase spans
   // PH register clocks because the device synchronises the pins.
   task automatic xfer(input  logic        rd,
                       input  logic [1:0]  len,
                       input  logic [12:0] addr,
                       input  logic [15:0] wdata,
                       input  logic        lsb,
                       output logic [15:0] rdata);
      logic [15:0] instr;
      int          b;
      instr = {rd, len, addr};
      rdata = 16'h0000;
      csb_n_o   = 1'b0;
      sdio_oe_o = 1'b1;
      for (int i = 0; i < 16; i++) begin
         b = lsb ? i : 15 - i;
         sdio_o = instr[b];
         tick(PH);
         sclk_o = 1'b1;
         tick(PH);
         sclk_o = 1'b0;
      end
      // The line turns round after the last instruction bit on a read.
      for (int i = 0; i < 8 * (len + 1); i++) begin
         b = 8 * (i / 8) + (lsb ? i % 8 : 7 - i % 8);
         if (rd) begin
            sdio_oe_o = 1'b0;
         end else begin
            sdio_o = wdata[b];
         end
         tick(PH);
         if (rd) begin
            rdata[b] = sdio_i;
         end
         sclk_o = 1'b1;
         tick(PH);
         sclk_o = 1'b0;
      end
      tick(PH);
      csb_n_o   = 1'b1;
      sdio_oe_o = 1'b0;
      tick(4);
   endtask : xfer

endmodule : serial_master_model

`default_nettype wire

// ---- verif/test_adc_config_register_map.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_adc_config_register_map;

   localparam logic [7:0] ID_VALUE = 8'hC3; // Arbitrary identity value.
   localparam logic [1:0] GRADE    = 2'h1;

   logic         clock_i;
   logic         rst_n_i;
   logic         ce;
   logic         csb_n;
   logic         sclk;
   logic         m_d;
   logic         m_oe;
   logic         dut_d;
   logic         dut_oe;
   logic         line;
   logic [199:0] active;
   logic         lsb_first;
   logic         lsb_mode;
   logic [15:0]  pair;
   int           bad_count;
   int           check_count;

   // No pull on the data line: an undriven line shows the inverse level.
   assign line = dut_oe ? dut_d : (m_oe ? m_d : ~m_d);

   adc_config_register_map #(
      .PART_ID    (ID_VALUE),
      .RATE_CLASS (GRADE)
   ) DUT (
      .clock_i       (clock_i),
      .rst_n_i       (rst_n_i),
      .ce_i          (ce),
      .csb_n_i       (csb_n),
      .sclk_i        (sclk),
      .sdio_i        (line),
      .sdio_o        (dut_d),
      .sdio_oe_o     (dut_oe),
      .active_regs_o (active),
      .lsb_first_o   (lsb_first)
   );

   serial_master_model #(
      .PH (6)
   ) master (
      .clock_i   (clock_i),
      .sdio_i    (line),
      .csb_n_o   (csb_n),
      .sclk_o    (sclk),
      .sdio_o    (m_d),
      .sdio_oe_o (m_oe)
   );

   // Register clock at 25 MHz.
   initial clock_i = 1'b0;
   always #20 clock_i = ~clock_i;

   // Prints the counts and the verdict, then stops the run.
   task automatic final_report;
      $display("Checks %0d, errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report

   // Compares one byte and counts the outcome.
   task automatic check8(input logic [7:0] got,
                         input logic [7:0] exp,
                         input string      what);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: %s is %h, expected %h", $time, what, got,
                  exp);
      end
   endtask : check8

   // Register write; the pause lets the write strobe and commit land.
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      logic [15:0] unused;
      master.xfer(1'h0, 2'h0, a, {8'h00, d}, lsb_mode, unused);
      master.tick(10);
   endtask : wr

   // Register read compared with the expected byte.
   task automatic rd(input logic [12:0] a, input logic [7:0] exp);
      logic [15:0] v;
      master.xfer(1'h1, 2'h0, a, 16'h0000, lsb_mode, v);
      check8(v[7:0], exp, "read data");
   endtask : rd

   // Compares one committed function byte, index counted from 0x08.
   task automatic act(input int i, input logic [7:0] exp);
      check8(active[8*i +: 8], exp, "active byte");
   endtask : act

   // Cuts a hang short; the tests take roughly 10800 clocks.
   initial begin
      repeat (60000) @(posedge clock_i);
      bad_count++;
      $display("Error at %0t: watchdog expired", $time);
      final_report();
   end

   // Main sequence.
   initial begin
      bad_count   = 0;
      check_count = 0;
      lsb_mode    = 1'b0;
      ce          = 1'h1;
      rst_n_i     = 1'b0;
      repeat (8) @(posedge clock_i);
      #1;
      rst_n_i = 1'b1;
      master.tick(8);
      // Defaults after power-on reset and the fixed identity registers.
      check8({7'h00, dut_oe}, 8'h00, "pin enable");
      check8({7'h00, lsb_first}, 8'h00, "bit order");
      act(1, 8'h01);
      act(12, 8'h01);
      act(0, 8'h00);
      rd(13'h0000, 8'h18);
      rd(13'h0001, ID_VALUE);
      rd(13'h0002, {2'b00, GRADE, 4'h0});
      rd(13'h0014, 8'h01);
      rd(13'h0020, 8'h00);
      rd(13'h0007, 8'h00);
      rd(13'h0021, 8'h00);
      // Read-only places keep their values when written.
      wr(13'h0001, 8'h00);
      wr(13'h0002, 8'h30);
      rd(13'h0001, ID_VALUE);
      rd(13'h0002, {2'b00, GRADE, 4'h0});
      // Function writes stay in the shadow copy until commit.
      wr(13'h0014, 8'h00);
      wr(13'h000B, 8'h3A);
      wr(13'h0008, 8'h02);
      rd(13'h0014, 8'h00);
      act(12, 8'h01);
      act(3, 8'h00);
      act(0, 8'h00);
      wr(13'h00FF, 8'h01);
      act(12, 8'h00);
      act(3, 8'h3A);
      act(0, 8'h02);
      rd(13'h00FF, 8'h00);
      // Bit order changes at once, then frames run least bit first.
      wr(13'h0000, 8'h5A);
      check8({7'h00, lsb_first}, 8'h01, "bit order");
      lsb_mode = 1'b1;
      rd(13'h0000, 8'h5A);
      rd(13'h000B, 8'h3A);
      wr(13'h0014, 8'h01);
      act(12, 8'h00);
      wr(13'h00FF, 8'h01);
      act(12, 8'h01);
      // Soft reset restores setup, shadow and active copies.
      wr(13'h0000, 8'h3C);
      lsb_mode = 1'b0;
      check8({7'h00, lsb_first}, 8'h00, "bit order");
      act(3, 8'h00);
      act(0, 8'h00);
      act(1, 8'h01);
      rd(13'h000B, 8'h00);
      rd(13'h0000, 8'h18);
      // A second hard reset in mid-run reloads the defaults.
      wr(13'h000B, 8'h3A);
      wr(13'h00FF, 8'h01);
      act(3, 8'h3A);
      rst_n_i = 1'b0;
      master.tick(2);
      rst_n_i = 1'b1;
      master.tick(8);
      act(3, 8'h00);
      rd(13'h000B, 8'h00);
      rd(13'h0014, 8'h01);
      // Two-byte frames walk down from 0x0C in MSB-first mode.
      master.xfer(1'h0, 2'h1, 13'h000C, 16'h2599, 1'h0, pair);
      master.tick(10);
      rd(13'h000C, 8'h99);
      rd(13'h000B, 8'h25);
      master.xfer(1'h1, 2'h1, 13'h000C, 16'h0000, 1'h0, pair);
      check8(pair[7:0], 8'h99, "first byte");
      check8(pair[15:8], 8'h25, "second byte");
      // A frame sent while the clock enable is low leaves no trace.
      ce = 1'h0;
      wr(13'h000C, 8'h00);
      ce = 1'h1;
      rd(13'h000C, 8'h99);
      act(4, 8'h00);
      final_report();
   end

endmodule : test_adc_config_register_map

`default_nettype wire
